// file: design/cesm_pkg.sv
// Package of constants and state types for the CAN error status and mask block
package cesm_pkg;

    // Register byte offsets on the plain register port
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;

    // Error and status field positions
    localparam int POS_RECESSIVE_RB = 15;
    localparam int POS_DOMINANT_RB = 14;
    localparam int POS_ACK = 13;
    localparam int POS_CHECKSUM = 12;
    localparam int POS_FORM = 11;
    localparam int POS_STUFF = 10;
    localparam int POS_TX_WARN = 9;
    localparam int POS_RX_WARN = 8;
    localparam int POS_IDLE = 7;
    localparam int POS_DIR = 6;
    localparam int POS_FAULT_LO = 4;
    localparam int POS_BOFF_IRQ = 2;
    localparam int POS_ERR_IRQ = 1;

    // Controller control bit positions
    localparam int POS_LISTEN_ONLY = 0;
    localparam int POS_ERR_IRQ_EN = 1;
    localparam int POS_BOFF_IRQ_EN = 2;

    // Warning threshold of both error counters
    localparam logic [7:0] WARN_LIMIT = 8'h60;

    // Fault confinement encodings
    localparam logic [1:0] FAULT_ACTIVE = 2'h0;
    localparam logic [1:0] FAULT_PASSIVE = 2'h1;

    // Values after reset
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [5:0] ERR_RST = 6'h00;

    // State of the main block: latched error bits are ordered 15 down to 10
    typedef struct packed {
        logic [5:0] err_bits;
        logic [1:0] fault;
        logic bus_off_irq;
        logic err_irq;
        logic [2:0] ctrl;
        logic [31:0] rdata;
    } cesm_main_t;

    // State of the buffer mask module
    typedef struct packed {
        logic [15:0] mask;
    } cesm_mask_t;

endpackage

// file: design/cesm_buf_if.sv
// Interface between the status core and the buffer interrupt mask module
interface cesm_buf_if;
    logic wr_mask;
    logic [15:0] wdata;
    logic [15:0] flags;
    logic [15:0] mask;
    logic [15:0] req;

    modport ctl_side (
        output wr_mask,
        output wdata,
        output flags,
        input mask,
        input req
    );

    modport mask_side (
        input wr_mask,
        input wdata,
        input flags,
        output mask,
        output req
    );
endinterface

// file: design/cesm_buf_mask.sv
// Buffer interrupt mask register and live per-buffer request gating
module cesm_buf_mask
    import cesm_pkg::*;
(
    input wire logic i_core_clk,    // Core clock
    input wire logic i_rstn,        // Asynchronous reset, active low
    cesm_buf_if.mask_side bif       // Mask write, flags in, requests out
);

    cesm_mask_t st_ff;
    cesm_mask_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (bif.wr_mask) begin
            nxt_st.mask = bif.wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff.mask <= MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bif.mask = st_ff.mask;
    // Request follows flag and mask with no register in between
    assign bif.req = bif.flags & st_ff.mask;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    mask_write_a: assert property (bif.wr_mask |=> st_ff.mask == $past(bif.wdata))
        else $error("mask write not stored");
    mask_gate_a: assert property (((bif.flags & ~st_ff.mask) != 16'h0000) |-> ((bif.req & ~st_ff.mask) == 16'h0000))
        else $error("masked buffer raised a request");
    live_request_a: assert property (bif.wr_mask ##1 1'b1 |-> bif.req == (bif.flags & $past(bif.wdata)))
        else $error("request did not follow new mask");

    buf_req_c: cover property (bif.wr_mask ##1 (bif.req != 16'h0000));

endmodule

// file: design/cesm_top.sv
// Error and status reporting, interrupt flags and buffer mask of a CAN controller
module cesm_top
    import cesm_pkg::*;
(
    input wire logic i_core_clk,            // Core clock, 250 MHz
    input wire logic i_rstn,                // Asynchronous reset, active low
    input wire logic i_soft_rst,            // Soft reset pulse from the controller
    input wire logic [7:0] i_addr,          // Register byte address
    input wire logic [31:0] i_wdata,        // Register write data
    input wire logic i_wr,                  // Write strobe
    input wire logic i_rd,                  // Read strobe
    output logic [31:0] o_rdata,            // Read data, cycle after the read strobe
    input wire logic i_ack_err,             // Missing acknowledge pulse
    input wire logic i_checksum_err,        // Checksum mismatch pulse
    input wire logic i_form_err,            // Frame form violation pulse
    input wire logic i_stuff_err,           // Bit stuffing violation pulse
    input wire logic i_recessive_rb_err,    // Recessive sent, dominant read back pulse
    input wire logic i_dominant_rb_err,     // Dominant sent, recessive read back pulse
    input wire logic [7:0] i_tx_err_cnt,    // Transmit error counter
    input wire logic [7:0] i_rx_err_cnt,    // Receive error counter
    input wire logic i_bus_idle,            // Bus idle level
    input wire logic i_transmitting,        // High while transmitting
    input wire logic [1:0] i_fault_state,   // Confinement state from the protocol engine
    input wire logic [15:0] i_buf_flags,    // Buffer completion flags
    output logic o_listen_only,             // Listen-only enable to the protocol engine
    output logic o_bus_off_irq,             // Bus-off interrupt request
    output logic o_error_irq,               // Error interrupt request
    output logic [15:0] o_buf_irq           // Per-buffer interrupt requests
);

    cesm_main_t st_ff;
    cesm_main_t nxt_st;
    cesm_buf_if bif ();

    logic rd_status;
    logic wr_status;
    logic [5:0] err_events;
    logic [1:0] fault_report;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // Assemble the status word from latched state and live inputs
    function automatic logic [31:0] status_word(input cesm_main_t s, input logic [1:0] fault,
                                                input logic [7:0] tx_cnt, input logic [7:0] rx_cnt,
                                                input logic idle, input logic dir);
        logic [31:0] w;
        w = 32'h0000_0000;  // Reserved positions stay zero
        w[POS_RECESSIVE_RB -: 6] = s.err_bits;
        w[POS_TX_WARN] = (tx_cnt >= WARN_LIMIT);
        w[POS_RX_WARN] = (rx_cnt >= WARN_LIMIT);
        w[POS_IDLE] = idle;
        w[POS_DIR] = dir;
        w[POS_FAULT_LO +: 2] = fault;
        w[POS_BOFF_IRQ] = s.bus_off_irq;
        w[POS_ERR_IRQ] = s.err_irq;
        status_word = w;
    endfunction

    assign rd_status = i_rd && hit(i_addr, OFF_STATUS);
    assign wr_status = i_wr && hit(i_addr, OFF_STATUS);

    // Event order matches status bits 15 down to 10
    assign err_events = {i_recessive_rb_err, i_dominant_rb_err,
                         i_ack_err, i_checksum_err, i_form_err, i_stuff_err};

    // Listen-only reports error-passive whatever the counters say
    assign fault_report = st_ff.ctrl[POS_LISTEN_ONLY] ? FAULT_PASSIVE : st_ff.fault;

    always_comb begin
        nxt_st = st_ff;

        // Read clears the latched bits; an event in the same cycle wins
        if (rd_status) begin
            nxt_st.err_bits = ERR_RST;
        end
        nxt_st.err_bits = nxt_st.err_bits | err_events;

        // Engine state is tracked only outside listen-only, so a soft reset leaves it alone there
        if (!st_ff.ctrl[POS_LISTEN_ONLY]) begin
            nxt_st.fault = i_soft_rst ? FAULT_ACTIVE : i_fault_state;
        end

        // Interrupt flags: write one clears, setting wins over clearing
        if (wr_status && i_wdata[POS_BOFF_IRQ]) begin
            nxt_st.bus_off_irq = 1'b0;
        end
        if (!st_ff.fault[1] && nxt_st.fault[1]) begin
            nxt_st.bus_off_irq = 1'b1;
        end
        if (wr_status && i_wdata[POS_ERR_IRQ]) begin
            nxt_st.err_irq = 1'b0;
        end
        if (st_ff.err_bits != ERR_RST) begin
            nxt_st.err_irq = 1'b1;
        end

        if (i_wr && hit(i_addr, OFF_CTRL)) begin
            nxt_st.ctrl = i_wdata[2:0];
        end

        // Read data stand for exactly one cycle
        nxt_st.rdata = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                OFF_STATUS: nxt_st.rdata = status_word(st_ff, fault_report, i_tx_err_cnt,
                                                       i_rx_err_cnt, i_bus_idle, i_transmitting);
                OFF_MASK: nxt_st.rdata = {16'h0000, bif.mask};
                OFF_CTRL: nxt_st.rdata = {29'h0000_0000, st_ff.ctrl};
                OFF_FLAGS: nxt_st.rdata = {16'h0000, i_buf_flags};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff.err_bits <= ERR_RST;
            st_ff.fault <= FAULT_ACTIVE;
            st_ff.bus_off_irq <= 1'b0;
            st_ff.err_irq <= 1'b0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.rdata <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Buffer mask lives in its own module
    assign bif.wr_mask = i_wr && hit(i_addr, OFF_MASK);
    assign bif.wdata = i_wdata[15:0];  // Upper write bits are dropped
    assign bif.flags = i_buf_flags;

    cesm_buf_mask u_buf_mask (
        .i_core_clk (i_core_clk),
        .i_rstn (i_rstn),
        .bif (bif.mask_side)
    );

    assign o_rdata = st_ff.rdata;
    assign o_listen_only = st_ff.ctrl[POS_LISTEN_ONLY];
    assign o_bus_off_irq = st_ff.bus_off_irq && st_ff.ctrl[POS_BOFF_IRQ_EN];
    assign o_error_irq = st_ff.err_irq && st_ff.ctrl[POS_ERR_IRQ_EN];
    assign o_buf_irq = bif.req;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    ack_latch_a: assert property (i_ack_err |=> st_ff.err_bits[3])
        else $error("ack error not latched");
    checksum_latch_a: assert property (i_checksum_err ##1 rd_status |=> o_rdata[POS_CHECKSUM])
        else $error("checksum error not reported");
    form_latch_a: assert property (i_form_err |=> st_ff.err_bits[1])
        else $error("form error not latched");
    stuff_hold_a: assert property (st_ff.err_bits[0] && !rd_status |=> st_ff.err_bits[0])
        else $error("stuff error lost before read");
    read_clear_a: assert property (rd_status && err_events == 6'h00 |=> st_ff.err_bits == 6'h00)
        else $error("status read did not clear errors");
    tx_warn_a: assert property (rd_status |=> o_rdata[POS_TX_WARN] == ($past(i_tx_err_cnt) >= 8'h60))
        else $error("transmit warning wrong");
    rx_warn_a: assert property (rd_status |=> o_rdata[POS_RX_WARN] == ($past(i_rx_err_cnt) >= 8'h60))
        else $error("receive warning wrong");
    idle_dir_a: assert property (rd_status |=> o_rdata[7:6] == $past({i_bus_idle, i_transmitting}))
        else $error("idle or direction wrong");
    fault_field_a: assert property (rd_status && !o_listen_only |=> o_rdata[5:4] == $past(st_ff.fault))
        else $error("fault field wrong");
    listen_passive_a: assert property (rd_status && o_listen_only |=> o_rdata[5:4] == 2'h1)
        else $error("listen-only not error-passive");
    soft_keep_a: assert property (o_listen_only && i_soft_rst |=> $stable(st_ff.fault))
        else $error("soft reset changed fault state");
    boff_set_a: assert property (!st_ff.fault[1] ##1 st_ff.fault[1] |-> st_ff.bus_off_irq)
        else $error("bus-off entry did not set flag");
    boff_req_a: assert property (o_bus_off_irq == (st_ff.bus_off_irq && st_ff.ctrl[POS_BOFF_IRQ_EN]))
        else $error("bus-off request mismatch");
    err_flag_a: assert property (st_ff.err_bits != 6'h00 |=> st_ff.err_irq)
        else $error("error flag not set");
    err_w0_a: assert property (st_ff.err_irq && wr_status && !i_wdata[POS_ERR_IRQ] |=> st_ff.err_irq)
        else $error("writing zero cleared error flag");
    err_req_a: assert property (o_error_irq == (st_ff.err_irq && st_ff.ctrl[POS_ERR_IRQ_EN]))
        else $error("error request mismatch");
    readback_a: assert property (i_recessive_rb_err || i_dominant_rb_err |=> st_ff.err_bits[5] || st_ff.err_bits[4])
        else $error("readback error not latched");
    reserved_zero_a: assert property (i_rd |=> o_rdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    event_kept_a: assert property (rd_status && i_ack_err |=> st_ff.err_bits[3])
        else $error("error lost in clearing read");
    boff_w0_a: assert property (st_ff.bus_off_irq && wr_status && !i_wdata[POS_BOFF_IRQ] |=> st_ff.bus_off_irq)
        else $error("writing zero cleared bus-off flag");
    status_gaps_a: assert property (rd_status |=> !o_rdata[3] && !o_rdata[0])
        else $error("reserved status bits not zero");

    ack_read_c: cover property (i_ack_err ##1 rd_status ##1 o_rdata[POS_ACK]);
    boff_irq_c: cover property (o_bus_off_irq ##1 wr_status ##1 !o_bus_off_irq);
    err_irq_c: cover property (o_error_irq);
    clash_c: cover property (rd_status && err_events != 6'h00);

endmodule

// file: sim/cesm_can_nodes.sv
// Behavioural model of the protocol engine and bus nodes that feed the status block
module cesm_can_nodes (
    input wire logic i_core_clk,    // Core clock
    output logic [5:0] o_err,       // Error pulses, bit 5 recessive readback down to bit 0 stuff
    output logic [7:0] o_tx_cnt,    // Transmit error counter
    output logic [7:0] o_rx_cnt,    // Receive error counter
    output logic o_idle,            // Bus idle level
    output logic o_tx,              // Transmitting level
    output logic [1:0] o_fault,     // Confinement state
    output logic [15:0] o_flags     // Buffer completion flags
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_err = 6'h00;
        o_tx_cnt = 8'h00;
        o_rx_cnt = 8'h00;
        o_idle = 1'b1;
        o_tx = 1'b0;
        o_fault = 2'h0;
        o_flags = 16'h0000;
    end

    // One-cycle error event
    task automatic pulse(input int idx);
        @(posedge i_core_clk);
        o_err[idx] <= 1'b1;
        @(posedge i_core_clk);
        o_err <= 6'h00;
    endtask

    task automatic levels(input logic [7:0] tx, input logic [7:0] rx, input logic idle, input logic dir,
                          input logic [1:0] f);
        @(posedge i_core_clk);
        o_tx_cnt <= tx;
        o_rx_cnt <= rx;
        o_idle <= idle;
        o_tx <= dir;
        o_fault <= f;
    endtask

    task automatic set_flags(input logic [15:0] f);
        @(posedge i_core_clk);
        o_flags <= f;
    endtask
endmodule

// file: sim/tb_can_error_status_irq_mask.sv
// Self-checking testbench of the CAN error status and buffer mask block
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_can_error_status_irq_mask
    import cesm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] tx;
        logic [7:0] rx;
        logic idle;
        logic dir;
        logic [1:0] f;
        logic [31:0] exp;
    } cesm_row_t;

    logic i_core_clk = 1'b0, i_rstn = 1'b0, i_soft_rst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [31:0] o_rdata, d;
    logic [5:0] err;
    logic [7:0] tx_cnt, rx_cnt;
    logic idle, dir, o_listen_only, o_bus_off_irq, o_error_irq;
    logic [1:0] fault;
    logic [15:0] flags, o_buf_irq;
    int n_errors = 0;
    int checks_done = 0;
    cesm_row_t rows [5] = '{'{8'h5F, 8'h5F, 1'b1, 1'b0, 2'h0, 32'h0000_0080},
                            '{8'h60, 8'h5F, 1'b0, 1'b1, 2'h0, 32'h0000_0240},
                            '{8'h5F, 8'h60, 1'b0, 1'b0, 2'h0, 32'h0000_0100},
                            '{8'hFF, 8'hC8, 1'b0, 1'b0, 2'h0, 32'h0000_0300},
                            '{8'h80, 8'h00, 1'b0, 1'b1, 2'h1, 32'h0000_0250}};

    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end

    cesm_can_nodes nodes (.i_core_clk(i_core_clk), .o_err(err), .o_tx_cnt(tx_cnt), .o_rx_cnt(rx_cnt),
        .o_idle(idle), .o_tx(dir), .o_fault(fault), .o_flags(flags));

    cesm_top dut_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_soft_rst(i_soft_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ack_err(err[3]),
        .i_checksum_err(err[2]), .i_form_err(err[1]), .i_stuff_err(err[0]), .i_recessive_rb_err(err[5]),
        .i_dominant_rb_err(err[4]), .i_tx_err_cnt(tx_cnt), .i_rx_err_cnt(rx_cnt), .i_bus_idle(idle),
        .i_transmitting(dir), .i_fault_state(fault), .i_buf_flags(flags), .o_listen_only(o_listen_only),
        .o_bus_off_irq(o_bus_off_irq), .o_error_irq(o_error_irq), .o_buf_irq(o_buf_irq));

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        `CHK(o_bus_off_irq, 1'b0)
        `CHK(o_buf_irq, 16'h0000)
        rd(OFF_MASK, d);
        `CHK(d, 32'h0000_0000)
        wr(OFF_CTRL, 32'h0000_0006);
        foreach (rows[k]) begin
            nodes.levels(rows[k].tx, rows[k].rx, rows[k].idle, rows[k].dir, rows[k].f);
            repeat (2) @(posedge i_core_clk);
            rd(OFF_STATUS, d);
            `CHK(d, rows[k].exp)
        end
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h0);
        for (int i = 0; i < 6; i++) begin
            nodes.pulse(i);
            repeat (3) @(posedge i_core_clk);
            `CHK(o_error_irq, 1'b1)
            rd(OFF_STATUS, d);
            `CHK(d, 32'h0000_0082 | (32'h1 << (10 + i)))
            rd(OFF_STATUS, d);
            `CHK(d, 32'h0000_0082)
            wr(OFF_STATUS, 32'h0000_0000);
            `CHK(o_error_irq, 1'b1)
            wr(OFF_STATUS, 32'h0000_0002);
            `CHK(o_error_irq, 1'b0)
        end
        // Event arriving in the very cycle of a clearing read
        fork
            nodes.pulse(3);
            rd(OFF_STATUS, d);
        join
        `CHK(d, 32'h0000_0080)
        rd(OFF_STATUS, d);
        `CHK(d, 32'h0000_2082)
        wr(OFF_STATUS, 32'h0000_0002);
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h2);
        repeat (3) @(posedge i_core_clk);
        `CHK(o_bus_off_irq, 1'b1)
        wr(OFF_CTRL, 32'h0000_0002);
        `CHK(o_bus_off_irq, 1'b0)
        wr(OFF_CTRL, 32'h0000_0006);
        wr(OFF_STATUS, 32'h0000_0000);
        rd(OFF_STATUS, d);
        `CHK(d, 32'h0000_00A4)
        wr(OFF_STATUS, 32'h0000_0004);
        `CHK(o_bus_off_irq, 1'b0)
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h0);
        repeat (2) @(posedge i_core_clk);
        wr(OFF_CTRL, 32'h0000_0007);
        `CHK(o_listen_only, 1'b1)
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h2);
        @(posedge i_core_clk);
        i_soft_rst <= 1'b1;
        @(posedge i_core_clk);
        i_soft_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        rd(OFF_STATUS, d);
        `CHK(d, 32'h0000_0090)
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h0);
        wr(OFF_CTRL, 32'h0000_0006);
        nodes.set_flags(16'hFFFF);
        wr(OFF_MASK, 32'hFFFF_A5A5);
        `CHK(o_buf_irq, 16'hA5A5)
        rd(OFF_MASK, d);
        `CHK(d, 32'h0000_A5A5)
        rd(OFF_FLAGS, d);
        `CHK(d, 32'h0000_FFFF)
        nodes.set_flags(16'h00F0);
        #1 `CHK(o_buf_irq, 16'h00A0)
        wr(OFF_MASK, 32'h0000_0030);
        `CHK(o_buf_irq, 16'h0030)
        rd(8'h10, d);
        `CHK(d, 32'h0000_0000)
        wr(OFF_STATUS, 32'hFFFF_0009);
        repeat (2) @(posedge i_core_clk);
        rd(OFF_STATUS, d);
        `CHK(d, 32'h0000_0080)
        // Mid-run reset with both requests pending
        nodes.pulse(0);
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h2);
        repeat (3) @(posedge i_core_clk);
        `CHK({o_bus_off_irq, o_error_irq}, 2'h3)
        i_rstn <= 1'b0;
        nodes.levels(8'h00, 8'h00, 1'b1, 1'b0, 2'h0);
        `CHK({o_listen_only, o_bus_off_irq, o_error_irq, o_buf_irq}, 19'h00000)
        i_rstn <= 1'b1;
        rd(OFF_STATUS, d);
        `CHK(d, 32'h0000_0080)
        rd(OFF_MASK, d);
        `CHK(d, 32'h0000_0000)
        conclude();
    end
endmodule
